/* File: design/memsel_pkg.sv */
/*
 * Shared constants and types for the memory page select decoder.
 * Assumes a 16-bit address, 8-bit data CPU on the same clock.
 */
package memsel_pkg;

    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W       = 16;
    localparam int DATA_W       = 8;
    localparam int USED_ADDR_W  = 14;   // Top two address bits ignored

    // ------------------------------------------------------------
    // Array organisations
    // ------------------------------------------------------------
    localparam int DEV_ADDR_W_1K   = 10;  // 1K x 1 devices
    localparam int PAGE_W_1K       = 4;
    localparam int PAGES_1K        = 16;
    localparam int DEV_ADDR_W_256  = 8;   // 256 x 4 devices
    localparam int PAGE_W_256      = 6;
    localparam int PAGES_256       = 64;
    localparam int PAGE_LSB_1K     = DEV_ADDR_W_1K;
    localparam int PAGE_LSB_256    = DEV_ADDR_W_256;

    // ------------------------------------------------------------
    // Buffered blocks of the array
    // ------------------------------------------------------------
    localparam int BLOCK_W   = 2;
    localparam int NUM_BLOCKS = 4;
    localparam int BLOCK_LSB = USED_ADDR_W - BLOCK_W;
    localparam int LANE_SH   = 3;         // Log2 of DATA_W

    typedef enum logic
    {
        ORG_1KX1,
        ORG_256X4
    } org_t;

endpackage

/* File: design/onehot_decoder.sv */
/*
 * Generic binary to one-hot decoder with enable.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps

module onehot_decoder
#(
    parameter int SEL_W = 4
)
(
    // Selection
    input  wire logic [SEL_W-1:0]      sel_i,
    input  wire logic                  en_i,
    // Decoded lines
    output logic      [(1<<SEL_W)-1:0] onehot_o
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // A single shifted one can never light two lines at once
    assign onehot_o = en_i ? ({{((1<<SEL_W)-1){1'b0}}, 1'b1} << sel_i)
                           : '0;

endmodule

/* File: design/memory_chip_select_decoder.sv */
/*
 * Page select, address split and data direction glue between an
 * 8-bit CPU and a 16K-byte static RAM/ROM array.
 * Assumes the CPU strobes, address and data are on CLK_I already;
 * memory devices answer combinationally to the registered selects.
 */
`timescale 1ns/1ps

module memory_chip_select_decoder
    import memsel_pkg::*;
(
    // Clock and reset
    input  wire logic                          CLK_I,
    input  wire logic                          SYS_RST_I,
    // Organisation strap (0: 1Kx1, 1: 256x4)
    input  wire logic                          ORG_SEL_I,
    // CPU side
    input  wire logic [ADDR_W-1:0]             ADDR_I,
    input  wire logic                          MEMORY_READ_STROBE_I,
    input  wire logic                          MEMORY_WRITE_STROBE_I,
    input  wire logic [DATA_W-1:0]             CPU_DATA_I,
    output logic      [DATA_W-1:0]             CPU_DATA_O,
    output logic                               CPU_DATA_OE_N_O,
    // Memory side
    output logic      [DEV_ADDR_W_1K-1:0]      MEM_ADDR_O,
    output logic      [PAGES_256-1:0]          PAGE_SEL_O,
    output logic                               MEM_OE_N_O,
    output logic                               MEM_WE_N_O,
    output logic      [DATA_W-1:0]             MEM_WDATA_O,
    input  wire logic [NUM_BLOCKS*DATA_W-1:0]  MEM_RDATA_I,
    output logic      [NUM_BLOCKS-1:0]         BLK_BUF_EN_N_O
);

    // ------------------------------------------------------------
    // Cycle qualification
    // ------------------------------------------------------------
    // Both strobes at once is illegal; treat it as no cycle at all
    wire  rd_cyc = MEMORY_READ_STROBE_I & ~MEMORY_WRITE_STROBE_I;
    wire  wr_cyc = MEMORY_WRITE_STROBE_I & ~MEMORY_READ_STROBE_I;
    wire  any_cyc = rd_cyc | wr_cyc;
    org_t org;
    assign org = org_t'(ORG_SEL_I);
    wire  org_1k = (org == ORG_1KX1);

    // ------------------------------------------------------------
    // Address split
    // ------------------------------------------------------------
    // Only the low 14 bits are looked at; top bits alias
    wire [USED_ADDR_W-1:0]   used_addr = ADDR_I[USED_ADDR_W-1:0];
    wire [PAGE_W_1K-1:0]     page_1k   = used_addr[PAGE_LSB_1K +: PAGE_W_1K];
    wire [PAGE_W_256-1:0]    page_256  =
        used_addr[PAGE_LSB_256 +: PAGE_W_256];
    wire [BLOCK_W-1:0]       blk_idx   = used_addr[BLOCK_LSB +: BLOCK_W];
    wire [DEV_ADDR_W_1K-1:0] nxt_mem_addr = org_1k
        ? used_addr[DEV_ADDR_W_1K-1:0]
        : {{(DEV_ADDR_W_1K-DEV_ADDR_W_256){1'b0}},
           used_addr[DEV_ADDR_W_256-1:0]};

    // ------------------------------------------------------------
    // Page and block decoders
    // ------------------------------------------------------------
    logic [PAGES_1K-1:0]   sel_1k;
    logic [PAGES_256-1:0]  sel_256;
    logic [NUM_BLOCKS-1:0] blk_rd;

    // Address zero lands on page zero in both organisations
    onehot_decoder #(.SEL_W(PAGE_W_1K)) u_dec_1k
    (
        .sel_i    (page_1k),
        .en_i     (any_cyc & org_1k),
        .onehot_o (sel_1k)
    );

    onehot_decoder #(.SEL_W(PAGE_W_256)) u_dec_256
    (
        .sel_i    (page_256),
        .en_i     (any_cyc & ~org_1k),
        .onehot_o (sel_256)
    );

    // Block buffers only open for a read into their own block
    onehot_decoder #(.SEL_W(BLOCK_W)) u_dec_blk
    (
        .sel_i    (blk_idx),
        .en_i     (rd_cyc),
        .onehot_o (blk_rd)
    );

    // Only one decoder is enabled, so the merge stays one-hot
    wire [PAGES_256-1:0] nxt_page_sel = org_1k
        ? {{(PAGES_256-PAGES_1K){1'b0}}, sel_1k}
        : sel_256;

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    logic [BLOCK_W-1:0] blk_ff;
    logic               rd_ff;
    logic [DATA_W-1:0]  cpu_data_ff;
    logic               cpu_oe_n_ff;
    // Pick the lane of the block whose buffer was opened
    wire  [DATA_W-1:0]  blk_rdata =
        MEM_RDATA_I[{blk_ff, {LANE_SH{1'b0}}} +: DATA_W];
    // Last read byte is held so the CPU side never sees a closed lane
    wire  [DATA_W-1:0]  nxt_cpu_data = rd_ff ? blk_rdata : cpu_data_ff;
    wire                nxt_cpu_oe_n = ~rd_ff;

    // ------------------------------------------------------------
    // Memory side next values
    // ------------------------------------------------------------
    logic [DEV_ADDR_W_1K-1:0] mem_addr_ff;
    logic [PAGES_256-1:0]     page_sel_ff;
    logic                     mem_oe_n_ff;
    logic                     mem_we_n_ff;
    logic [DATA_W-1:0]        mem_wdata_ff;
    logic [NUM_BLOCKS-1:0]    blk_buf_n_ff;
    // Enables are active low, so an idle bus leaves every one high
    wire                      nxt_mem_oe_n  = ~rd_cyc;
    wire                      nxt_mem_we_n  = ~wr_cyc;
    wire  [NUM_BLOCKS-1:0]    nxt_blk_buf_n = ~blk_rd;

    // ------------------------------------------------------------
    // Memory side registers
    // ------------------------------------------------------------
    // Registered so no select glitches while the address settles
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            mem_addr_ff <= '0;
            page_sel_ff <= '0;
        end
        else
        begin
            mem_addr_ff <= nxt_mem_addr;
            page_sel_ff <= nxt_page_sel;
        end
    end

    // Strobes and block buffers come out of reset closed
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            mem_oe_n_ff  <= 1'b1;
            mem_we_n_ff  <= 1'b1;
            blk_buf_n_ff <= '1;
        end
        else
        begin
            mem_oe_n_ff  <= nxt_mem_oe_n;
            mem_we_n_ff  <= nxt_mem_we_n;
            blk_buf_n_ff <= nxt_blk_buf_n;
        end
    end

    // Write data follows the bus every cycle; only the strobe matters
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            mem_wdata_ff <= '0;
        end
        else
        begin
            mem_wdata_ff <= CPU_DATA_I;
        end
    end

    // ------------------------------------------------------------
    // CPU side registers
    // ------------------------------------------------------------
    // Read pipeline remembers which block the lane must come from
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            blk_ff <= '0;
            rd_ff  <= 1'b0;
        end
        else
        begin
            blk_ff <= blk_idx;
            rd_ff  <= rd_cyc;
        end
    end

    // Data returns one cycle after the selects; enable tracks it
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            cpu_data_ff <= '0;
            cpu_oe_n_ff <= 1'b1;
        end
        else
        begin
            cpu_data_ff <= nxt_cpu_data;
            cpu_oe_n_ff <= nxt_cpu_oe_n;
        end
    end

    // ------------------------------------------------------------
    // Output ports
    // ------------------------------------------------------------
    // Every port is a plain copy of a flip-flop
    assign MEM_ADDR_O      = mem_addr_ff;
    assign PAGE_SEL_O      = page_sel_ff;
    assign MEM_OE_N_O      = mem_oe_n_ff;
    assign MEM_WE_N_O      = mem_we_n_ff;
    assign MEM_WDATA_O     = mem_wdata_ff;
    assign BLK_BUF_EN_N_O  = blk_buf_n_ff;
    assign CPU_DATA_O      = cpu_data_ff;
    assign CPU_DATA_OE_N_O = cpu_oe_n_ff;

endmodule

/* File: tb/memsel_sva.sv */
/* Port checker for the page select decoder.
   Assumes it is bound to the top module, one clock, async reset. */
`timescale 1ns/1ps
module memsel_sva
(
    // Clock, reset and CPU side
    input wire logic        CLK_I, SYS_RST_I, ORG_SEL_I,
    input wire logic        MEMORY_READ_STROBE_I, MEMORY_WRITE_STROBE_I,
    input wire logic [15:0] ADDR_I,
    // CPU data enable and memory side
    input wire logic        CPU_DATA_OE_N_O, MEM_OE_N_O, MEM_WE_N_O,
    input wire logic [9:0]  MEM_ADDR_O,
    input wire logic [63:0] PAGE_SEL_O,
    input wire logic [3:0]  BLK_BUF_EN_N_O
);
    // Both strobes high counts as no cycle
    wire logic rd  = MEMORY_READ_STROBE_I & ~MEMORY_WRITE_STROBE_I;
    wire logic wr  = MEMORY_WRITE_STROBE_I & ~MEMORY_READ_STROBE_I;
    wire logic cyc = rd | wr;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence rd_s; rd; endsequence
    sequence drv_s; ##2 !CPU_DATA_OE_N_O; endsequence
    chk_sel_onehot: assert property ($onehot0(PAGE_SEL_O))
        else $error("more than one page select");
    chk_idle_nosel: assert property (!cyc |=> PAGE_SEL_O == '0)
        else $error("select without strobe");
    chk_read_oe: assert property (rd |=> !MEM_OE_N_O && MEM_WE_N_O)
        else $error("read enables wrong");
    chk_nonread_oe: assert property (!rd |=> MEM_OE_N_O)
        else $error("output enable outside read");
    chk_write_we: assert property (wr |=> !MEM_WE_N_O)
        else $error("write enable missing");
    chk_page_small: assert property (cyc && !ORG_SEL_I |=>
        PAGE_SEL_O == 64'h1 << $past(ADDR_I[13:10]) &&
        MEM_ADDR_O == $past(ADDR_I[9:0])) else $error("1K page wrong");
    chk_page_large: assert property (cyc && ORG_SEL_I |=>
        PAGE_SEL_O == 64'h1 << $past(ADDR_I[13:8]) &&
        MEM_ADDR_O == {2'h0, $past(ADDR_I[7:0])}) else $error("256 page");
    chk_blk_buf: assert property (rd |=>
        BLK_BUF_EN_N_O == ~(4'h1 << $past(ADDR_I[13:12])))
        else $error("block buffer wrong");
    chk_blk_idle: assert property (!rd |=> BLK_BUF_EN_N_O == 4'hf)
        else $error("block buffer outside read");
    chk_cpu_drive: assert property (rd_s |-> drv_s)
        else $error("cpu bus not driven");
endmodule
bind memory_chip_select_decoder memsel_sva u_sva (.CLK_I, .SYS_RST_I,
    .ORG_SEL_I, .MEMORY_READ_STROBE_I, .MEMORY_WRITE_STROBE_I, .ADDR_I,
    .CPU_DATA_OE_N_O, .MEM_OE_N_O, .MEM_WE_N_O, .MEM_ADDR_O, .PAGE_SEL_O,
    .BLK_BUF_EN_N_O);

/* File: tb/mem_model.sv */
/* Behavioural memory array, four buffered blocks.
   Assumes the decoder gives registered enables. */
`timescale 1ns/1ps
module mem_model
(
    // From decoder
    input  wire logic [9:0]  mem_addr_i,
    input  wire logic        mem_oe_n_i,
    input  wire logic [3:0]  buf_en_n_i,
    // To decoder
    output logic      [31:0] rdata_o
);
    // Released lanes show the inverse, so a stray capture is seen
    always_comb
    begin
        for (int b = 0; b < 4; b++)
        begin
            rdata_o[8*b +: 8] = mem_addr_i[7:0] + 8'(b * 64);
            if (mem_oe_n_i || buf_en_n_i[b])
                rdata_o[8*b +: 8] = ~rdata_o[8*b +: 8];
        end
    end
endmodule

/* File: tb/memory_chip_select_decoder_tb.sv */
/* Self-checking bench for the page select decoder.
   Assumes the memory model answers combinationally in the same cycle as the selects. */
`timescale 1ns/1ps
module memory_chip_select_decoder_tb;
    import memsel_pkg::*;
    logic clk, rst, org, rd, wr, cpu_oe_n, mem_oe_n, mem_we_n;
    logic [15:0] addr;
    logic [7:0]  cdi, cdo, wdata;
    logic [9:0]  mem_addr;
    logic [63:0] page_sel;
    logic [3:0]  blk;
    logic [31:0] rdata;
    logic [15:0] at [6] = '{16'h0000, 16'hc000, 16'h3fff, 16'h1234,
                           16'h2abc, 16'h5bcd};
    int fails, n_checks, cyc;
    memory_chip_select_decoder dut (.CLK_I(clk), .SYS_RST_I(rst),
        .ORG_SEL_I(org), .ADDR_I(addr), .MEMORY_READ_STROBE_I(rd),
        .MEMORY_WRITE_STROBE_I(wr), .CPU_DATA_I(cdi), .CPU_DATA_O(cdo),
        .CPU_DATA_OE_N_O(cpu_oe_n), .MEM_ADDR_O(mem_addr),
        .PAGE_SEL_O(page_sel), .MEM_OE_N_O(mem_oe_n), .MEM_WE_N_O(mem_we_n),
        .MEM_WDATA_O(wdata), .MEM_RDATA_I(rdata), .BLK_BUF_EN_N_O(blk));
    mem_model mem (.mem_addr_i(mem_addr), .mem_oe_n_i(mem_oe_n),
        .buf_en_n_i(blk), .rdata_o(rdata));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task check(input string nm, input logic [79:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task stop_test;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One read, then the captured lane two edges later
    task t_read(input logic o, input logic [15:0] a);
        logic [63:0] es;
        logic [3:0]  eb;
        logic [7:0]  ed;
        es = o ? 64'h1 << a[13:8] : 64'h1 << a[13:10];
        eb = ~(4'h1 << a[13:12]);
        ed = a[7:0] + {a[13:12], 6'h0};
        org = o;
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        check("sel", page_sel, es);
        check("maddr", mem_addr, o ? {2'h0, a[7:0]} : a[9:0]);
        check("oe", {mem_oe_n, mem_we_n, blk}, {2'b01, eb});
        @(negedge clk);
        check("rd", {cpu_oe_n, cdo}, {1'b0, ed});
        check("idle", page_sel, 64'h0);
    endtask
    task t_write(input logic [15:0] a, input logic [7:0] d);
        org = 1'b0;
        addr = a;
        wr = 1'b1;
        cdi = d;
        @(negedge clk);
        wr = 1'b0;
        check("wsel", page_sel, 64'h1 << a[13:10]);
        check("wr", {cpu_oe_n, mem_oe_n, mem_we_n, blk}, 7'h6f);
        check("wdata", wdata, d);
        @(negedge clk);
    endtask
    // Both strobes at once must open no cycle
    task t_both;
        addr = 16'h1400;
        rd = 1'b1;
        wr = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        wr = 1'b0;
        check("both", {page_sel, mem_oe_n, mem_we_n, blk}, 70'h3f);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc >= 500)
        begin
            fails++;
            stop_test;
        end
    end
    initial
    begin
        {rst, org, rd, wr, addr, cdi} = 28'h8000000;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        check("rst", {page_sel, cpu_oe_n, mem_oe_n, mem_we_n, blk}, 71'h7f);
        check("rstd", {cdo, wdata, mem_addr}, 26'h0);
        for (int o = 0; o < 2; o++)
            foreach (at[i]) t_read(o[0], at[i]);
        t_write(16'h3c55, 8'ha5);
        t_write(16'h0000, 8'h5a);
        t_both;
        stop_test;
    end
endmodule
